// *** rtl/dfusr_pkg.sv ***
package dfusr_pkg;
	// Clock and millisecond timing.
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MS_NS = 1000000;
	// A least wait, so the count rounds up.
	localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Functional descriptor layout.
	localparam logic [7:0] FD_LEN = 8'h07;
	localparam logic [7:0] FD_TYPE = 8'h21;
	localparam logic [3:0] FD_BYTES = 4'h7;
	localparam logic [3:0] STAT_BYTES = 4'h6;
	localparam logic [3:0] STATE_BYTES = 4'h1;
	localparam int ATTR_DNLOAD = 0;
	localparam int ATTR_UPLOAD = 1;
	localparam int ATTR_MANIF = 2;
	localparam int CTRL_IMG_DONE = 3;
	// Setup packet codes.
	localparam logic [7:0] RT_STD_IN = 8'h80;
	localparam logic [7:0] RT_CLASS_IN = 8'hA1;
	localparam logic [7:0] RT_CLASS_OUT = 8'h21;
	localparam logic [7:0] RQ_GET_DESC = 8'h06;
	localparam logic [7:0] RQ_DETACH = 8'h00;
	localparam logic [7:0] RQ_DNLOAD = 8'h01;
	localparam logic [7:0] RQ_GETSTATUS = 8'h03;
	localparam logic [7:0] RQ_CLRSTATUS = 8'h04;
	localparam logic [7:0] RQ_GETSTATE = 8'h05;
	localparam logic [7:0] RQ_ABORT = 8'h06;
	// Status codes.
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_NOTDONE = 8'h09;
	localparam logic [7:0] ST_USBR = 8'h0C;
	localparam logic [7:0] ST_UNKNOWN = 8'h0E;
	localparam logic [7:0] ST_STALLEDPK = 8'h0F;
	// Device state codes.
	localparam logic [3:0] DS_APP_IDLE = 4'h0;
	localparam logic [3:0] DS_APP_DETACH = 4'h1;
	localparam logic [3:0] DS_DFU_IDLE = 4'h2;
	localparam logic [3:0] DS_DN_SYNC = 4'h3;
	localparam logic [3:0] DS_MANIFEST = 4'h7;
	localparam logic [3:0] DS_UP_IDLE = 4'h9;
	localparam logic [3:0] DS_ERROR = 4'hA;
	// Register byte offsets.
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_DETACH = 12'h004;
	localparam logic [11:0] REG_XFER = 12'h008;
	localparam logic [11:0] REG_POLL = 12'h00C;
	localparam logic [11:0] REG_STATUS = 12'h010;
	localparam logic [11:0] REG_LASTREQ = 12'h014;
	// Values after reset.
	localparam logic [3:0] CTRL_RST = 4'h3;
	localparam logic [15:0] DETACH_RST = 16'h00FF;
	localparam logic [15:0] XFER_RST = 16'h0040;
	localparam logic [23:0] POLL_RST = 24'h000005;
	localparam logic [3:0] STATE_RST = DS_DFU_IDLE;
	// Response sender states.
	typedef enum logic {TX_IDLE, TX_SEND} dfusr_tx_e;
endpackage

// *** rtl/dfusr_tmr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Detach timer control between the responder and its timer.
interface dfusr_tmr_if;
	logic start; // One-cycle pulse that loads and runs the timer.
	logic stop; // One-cycle pulse that halts the timer.
	logic [15:0] load_ms; // Wait in milliseconds.
	logic running; // Timer is counting.
	logic expired; // One-cycle pulse when the wait ends.
	modport ctl (output start, output stop, output load_ms,
		input running, input expired);
	modport timer (input start, input stop, input load_ms,
		output running, output expired);
endinterface // dfusr_tmr_if
`default_nettype wire

// *** rtl/dfusr_ms_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfusr_ms_timer import dfusr_pkg::*; #(
	parameter int unsigned CYC_PER_MS = MS_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	dfusr_tmr_if.timer tif
);
	localparam int PW = $clog2(CYC_PER_MS + 1);
	localparam logic [PW-1:0] PRE_TOP = PW'(CYC_PER_MS - 1);
	logic [PW-1:0] pre_reg, pre_next; // Cycles within the current ms.
	logic [15:0] ms_reg, ms_next; // Milliseconds still to wait.
	logic run_reg, run_next;
	logic exp_reg, exp_next;
	logic ms_tick; // One-cycle enable, once per millisecond.

	assign ms_tick = run_reg && (pre_reg == PRE_TOP);
	assign tif.running = run_reg;
	assign tif.expired = exp_reg;

	// Countdown; a load of zero still waits one whole millisecond.
	always_comb begin
		pre_next = pre_reg;
		ms_next = ms_reg;
		run_next = run_reg;
		exp_next = 1'b0;
		if (run_reg) begin
			pre_next = ms_tick ? '0 : pre_reg + PW'(1);
		end
		if (ms_tick) begin
			if (ms_reg <= 16'h0001) begin
				run_next = 1'b0;
				exp_next = 1'b1;
			end else begin
				ms_next = ms_reg - 16'h0001;
			end
		end
		if (tif.start) begin
			ms_next = tif.load_ms;
			pre_next = '0;
			run_next = 1'b1;
		end else if (tif.stop) begin
			run_next = 1'b0;
		end
	end

	// Registers only.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pre_reg <= '0;
			ms_reg <= 16'h0000;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			ms_reg <= ms_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end
endmodule // dfusr_ms_timer
`default_nettype wire

// *** rtl/dfusr_responder.sv ***
// Overview of operation
// - Descriptor length 07h, type 21h.
// - Attribute bit0 download, bit1 upload.
// - Attribute bit2 means manifestation tolerant.
// - Detach wait field; timeout resumes application.
// - Shorter host detach timeout is used.
// - Offset 5 holds largest transfer size.
// - Status poll returns six byte payload.
// - Byte 0 holds latest status code.
// - Bytes 1-3 give poll wait, ms.
// - Byte 4 reports the state entered next.
// - Byte 5 holds status string index.
// - Status codes 00h to 05h.
// - Status codes 06h to 08h.
// - Early zero-length download reports 09h.
// - Corrupt firmware reports 0Ah.
// - Codes 0Bh vendor, 0Ch reset, 0Dh power.
// - 0Eh unknown, 0Fh stalled request.
// - State value 2 is upgrade idle.
// - Reported error enters error state.
// - Clear gives no error, upgrade idle.
`timescale 1ns/1ps
`default_nettype none
module dfusr_responder import dfusr_pkg::*; #(
	parameter int unsigned CYC_PER_MS = MS_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic req_valid,
	input wire logic [7:0] req_type,
	input wire logic [7:0] req_code,
	input wire logic [15:0] req_value,
	input wire logic [15:0] req_length,
	input wire logic usb_reset,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	output logic req_ack,
	output logic req_stall,
	output logic [3:0] dfu_state
);
	// Software registers.
	logic [3:0] ctrl_reg, ctrl_next; // Attributes and image-done flag.
	logic [15:0] detach_reg, detach_next; // Longest detach wait, ms.
	logic [15:0] xfer_reg, xfer_next; // Largest control write.
	logic [23:0] poll_reg, poll_next; // Poll wait, ms.
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	// Protocol state.
	dfusr_tx_e tx_reg, tx_next;
	logic [55:0] buf_reg, buf_next; // Response bytes, next byte lowest.
	logic [3:0] cnt_reg, cnt_next; // Bytes still to send.
	logic last_reg, last_next;
	logic [7:0] status_reg, status_next;
	logic [7:0] istr_reg, istr_next;
	logic [3:0] state_reg, state_next;
	logic [3:0] pend_reg, pend_next; // State taken once sending ends.
	logic [15:0] lastreq_reg, lastreq_next;
	logic ack_reg, ack_next;
	logic stall_reg, stall_next;
	// Decode helpers.
	logic access, commit, mapped;
	logic fw_stat_wr;
	logic [7:0] fw_code;
	logic class_out, class_in;
	logic start_desc, start_stat, start_clr, start_detach, start_nd;
	logic [3:0] stat_state;
	logic [15:0] wait_ms;

	dfusr_tmr_if tif ();

	dfusr_ms_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_timer (
		.clock(clock),
		.rstn(rstn),
		.tif(tif)
	);

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign tx_valid = (tx_reg == TX_SEND);
	assign tx_data = buf_reg[7:0];
	assign tx_last = last_reg;
	assign req_ack = ack_reg;
	assign req_stall = stall_reg;
	assign dfu_state = state_reg;

	// One wait state: data is set up in the first access cycle and the
	// write lands on the edge where the master sees pready.
	assign access = psel && penable;
	assign commit = access && pready_reg;
	assign fw_stat_wr = commit && pwrite && (paddr == REG_STATUS)
		&& !pslverr_reg;
	always_comb begin
		unique case (paddr)
			REG_CTRL, REG_DETACH, REG_XFER, REG_POLL,
			REG_STATUS, REG_LASTREQ: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Register file next values.
	always_comb begin
		ctrl_next = ctrl_reg;
		detach_next = detach_reg;
		xfer_next = xfer_reg;
		poll_next = poll_reg;
		prdata_next = prdata_reg;
		pready_next = access && !pready_reg;
		pslverr_next = access && !pready_reg && !mapped;
		if (access && !pready_reg) begin
			// Unmapped reads return zero.
			unique case (paddr)
				REG_CTRL: prdata_next = {28'h0, ctrl_reg};
				REG_DETACH: prdata_next = {16'h0, detach_reg};
				REG_XFER: prdata_next = {16'h0, xfer_reg};
				REG_POLL: prdata_next = {8'h0, poll_reg};
				REG_STATUS: prdata_next = {12'h0, state_reg,
					istr_reg, status_reg};
				REG_LASTREQ: prdata_next = {15'h0, tif.running,
					lastreq_reg};
				default: prdata_next = 32'h0;
			endcase
		end
		if (commit && pwrite) begin
			unique case (paddr)
				REG_CTRL: ctrl_next = pwdata[3:0];
				REG_DETACH: detach_next = pwdata[15:0];
				REG_XFER: xfer_next = pwdata[15:0];
				REG_POLL: poll_next = pwdata[23:0];
				default: ;
			endcase
		end
	end

	// Register file flip-flops.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RST;
			detach_reg <= DETACH_RST;
			xfer_reg <= XFER_RST;
			poll_reg <= POLL_RST;
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			detach_reg <= detach_next;
			xfer_reg <= xfer_next;
			poll_reg <= poll_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign class_out = (req_type == RT_CLASS_OUT);
	assign class_in = (req_type == RT_CLASS_IN);
	// firmware codes: out-of-range codes become unknown.
	assign fw_code = (pwdata[7:0] > ST_STALLEDPK) ? ST_UNKNOWN : pwdata[7:0];
	// shorter detach: the wait loaded never exceeds the advertised one.
	assign wait_ms = (req_value < detach_reg) ? req_value : detach_reg;
	// error reporting: any error status moves the device to error.
	assign stat_state = (status_reg != ST_OK) ? DS_ERROR : state_reg;

	// Request decode, response build and state tracking.
	always_comb begin
		tx_next = tx_reg;
		buf_next = buf_reg;
		cnt_next = cnt_reg;
		last_next = last_reg;
		status_next = status_reg;
		istr_next = istr_reg;
		state_next = state_reg;
		pend_next = pend_reg;
		lastreq_next = lastreq_reg;
		ack_next = 1'b0;
		stall_next = 1'b0;
		start_desc = 1'b0;
		start_stat = 1'b0;
		start_clr = 1'b0;
		start_detach = 1'b0;
		start_nd = 1'b0;
		tif.start = 1'b0;
		tif.stop = 1'b0;
		tif.load_ms = wait_ms;
		// Firmware reports the result of the requests it handles.
		if (fw_stat_wr) begin
			status_next = fw_code;
			istr_next = pwdata[15:8];
			if (pwdata[20]) begin
				state_next = pwdata[19:16];
			end
		end
		// Sending: shift out one byte per accepted handshake.
		if (tx_reg == TX_SEND && tx_ready) begin
			buf_next = {8'h00, buf_reg[55:8]};
			cnt_next = cnt_reg - 4'h1;
			last_next = (cnt_reg == 4'h2);
			if (cnt_reg == 4'h1) begin
				tx_next = TX_IDLE;
				// next state: taken only once the response is out.
				state_next = pend_reg;
			end
		end
		if (req_valid) begin
			lastreq_next = {req_code, req_type};
			if (req_type == RT_STD_IN && req_code == RQ_GET_DESC
				&& req_value[15:8] == FD_TYPE) begin
				start_desc = 1'b1;
				buf_next = {xfer_reg[15:8], xfer_reg[7:0],
					detach_reg[15:8], detach_reg[7:0],
					5'h00, ctrl_reg[ATTR_MANIF],
					ctrl_reg[ATTR_UPLOAD], ctrl_reg[ATTR_DNLOAD],
					FD_TYPE, FD_LEN};
				cnt_next = FD_BYTES;
				pend_next = state_reg;
			end else if (class_in && req_code == RQ_GETSTATUS
				&& req_value == 16'h0000 && req_length == 16'h0006) begin
				// status poll answered with six bytes.
				start_stat = 1'b1;
				// payload order.
				// The state byte is zero-extended so the string index
				// lands in byte 5; the payload fills the low 48 bits and the top byte is not sent.
				buf_next = {8'h00, istr_reg, 4'h0, stat_state,
					poll_reg[23:16], poll_reg[15:8], poll_reg[7:0],
					status_reg};
				cnt_next = STAT_BYTES;
				pend_next = stat_state;
			end else if (class_in && req_code == RQ_GETSTATE
				&& req_length == 16'h0001) begin
				buf_next = {52'h0, state_reg};
				cnt_next = STATE_BYTES;
				pend_next = state_reg;
			end else if (class_out && req_code == RQ_CLRSTATUS
				&& req_value == 16'h0000 && req_length == 16'h0000) begin
				// clear: no error, back to upgrade idle.
				start_clr = 1'b1;
				status_next = ST_OK;
				state_next = DS_DFU_IDLE;
				ack_next = 1'b1;
			end else if (class_out && req_code == RQ_ABORT
				&& state_reg != DS_ERROR) begin
				status_next = ST_OK;
				state_next = DS_DFU_IDLE;
				ack_next = 1'b1;
			end else if (class_out && req_code == RQ_DETACH
				&& state_reg == DS_APP_IDLE) begin
				start_detach = 1'b1;
				tif.start = 1'b1;
				state_next = DS_APP_DETACH;
				ack_next = 1'b1;
			end else if (class_out && req_code == RQ_DNLOAD
				&& state_reg != DS_ERROR) begin
				if (req_length == 16'h0000 && !ctrl_reg[CTRL_IMG_DONE]) begin
					start_nd = 1'b1;
					status_next = ST_NOTDONE;
					ack_next = 1'b1;
				end
			end else if (class_in || class_out) begin
				stall_next = 1'b1;
				status_next = ST_STALLEDPK;
			end
			// Responses with data start sending; a new setup cancels
			// any response still in flight.
			if (start_desc || start_stat || (class_in
				&& req_code == RQ_GETSTATE && req_length == 16'h0001)) begin
				tx_next = TX_SEND;
				last_next = (cnt_next == 4'h1);
			end else begin
				tx_next = TX_IDLE;
			end
		end
		// timeout: no reset came, resume the application.
		if (tif.expired && state_reg == DS_APP_DETACH) begin
			state_next = DS_APP_IDLE;
		end
		// reset after detach enters upgrade idle.
		if (usb_reset) begin
			tx_next = TX_IDLE;
			if (state_reg == DS_APP_DETACH) begin
				tif.stop = 1'b1;
				state_next = DS_DFU_IDLE;
			end else if (state_reg >= DS_DN_SYNC
				&& state_reg <= DS_MANIFEST || state_reg == DS_UP_IDLE) begin
				// reset in mid transfer is unexpected.
				status_next = ST_USBR;
				state_next = DS_ERROR;
			end
		end
	end

	// Protocol flip-flops.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_reg <= TX_IDLE;
			buf_reg <= 56'h0;
			cnt_reg <= 4'h0;
			last_reg <= 1'b0;
			status_reg <= ST_OK;
			istr_reg <= 8'h00;
			state_reg <= STATE_RST;
			pend_reg <= STATE_RST;
			lastreq_reg <= 16'h0000;
			ack_reg <= 1'b0;
			stall_reg <= 1'b0;
		end else begin
			tx_reg <= tx_next;
			buf_reg <= buf_next;
			cnt_reg <= cnt_next;
			last_reg <= last_next;
			status_reg <= status_next;
			istr_reg <= istr_next;
			state_reg <= state_next;
			pend_reg <= pend_next;
			lastreq_reg <= lastreq_next;
			ack_reg <= ack_next;
			stall_reg <= stall_next;
		end
	end

	// Checks on the responder's own outputs and internal registers.
	// descriptor head
	desc_head_a: assert property (@(posedge clock) disable iff (!rstn)
		start_desc && !usb_reset |=> (tx_valid && tx_data == 8'h07)
		and (tx_ready && !req_valid && !usb_reset |=> tx_data == 8'h21))
		else $error("descriptor does not open with 07h 21h");
	attr_byte_a: assert property (@(posedge clock) disable iff (!rstn)
		start_desc && !usb_reset |=> buf_reg[23:16] == {5'h00, ctrl_reg[2:0]})
		else $error("attribute byte differs from control bits");
	detach_lim_a: assert property (@(posedge clock) disable iff (!rstn)
		tif.start |-> tif.load_ms <= detach_reg && tif.load_ms <= req_value)
		else $error("detach wait exceeds a limit");
	stat_len_a: assert property (@(posedge clock) disable iff (!rstn)
		start_stat && !usb_reset |=> tx_valid && cnt_reg == 4'h6 && !tx_last)
		else $error("status payload is not six bytes");
	next_state_a: assert property (@(posedge clock) disable iff (!rstn)
		tx_valid && tx_ready && tx_last && !req_valid && !usb_reset
		&& !fw_stat_wr |=> !tx_valid && dfu_state == $past(pend_reg))
		else $error("state not taken after last byte");
	err_state_a: assert property (@(posedge clock) disable iff (!rstn)
		start_stat && status_reg != ST_OK && !usb_reset
		|=> buf_reg[39:32] == {4'h0, DS_ERROR})
		else $error("error status without error state");
	clr_done_a: assert property (@(posedge clock) disable iff (!rstn)
		start_clr && !usb_reset |=> status_reg == ST_OK
		&& dfu_state == DS_DFU_IDLE && req_ack)
		else $error("clear did not reach idle with ok");
	not_done_a: assert property (@(posedge clock) disable iff (!rstn)
		start_nd && !usb_reset |=> status_reg == 8'h09)
		else $error("early zero-length download not flagged");
	stall_st_a: assert property (@(posedge clock) disable iff (!rstn)
		req_stall |-> status_reg == 8'h0F || $past(usb_reset))
		else $error("stall without stalled status");
endmodule // dfusr_responder
`default_nettype wire

// *** tb/dfusr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural USB host facing the control endpoint of the responder.
module dfusr_host_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	output logic req_valid,
	output logic [7:0] req_type,
	output logic [7:0] req_code,
	output logic [15:0] req_value,
	output logic [15:0] req_length
);
	logic slow = 1'b0; // When set the host takes one byte in four cycles.
	logic [8:0] rx_q[$]; // Received bytes, each with its last flag on top.
	logic [3:0] tick = 4'h0; // Free count that paces a slow host.
	initial begin
		tx_ready = 1'b0;
		req_valid = 1'b0;
		req_type = 8'h00;
		req_code = 8'h00;
		req_value = 16'h0000;
		req_length = 16'h0000;
	end
	// Bytes are taken only on an edge that sees valid and ready together.
	always @(posedge clock) begin
		tick <= tick + 4'h1;
		tx_ready <= rstn && (!slow || tick[1:0] == 2'h0);
		if (tx_valid && tx_ready) begin
			rx_q.push_back({tx_last, tx_data});
		end
	end
	// setup packet issue.
	// The fields are inverted once released, so stale values never match.
	task automatic send(input logic [7:0] t, input logic [7:0] c,
		input logic [15:0] v, input logic [15:0] l);
		@(posedge clock);
		req_valid <= 1'b1;
		req_type <= t;
		req_code <= c;
		req_value <= v;
		req_length <= l;
		@(posedge clock);
		req_valid <= 1'b0;
		req_type <= ~t;
		req_code <= ~c;
		req_value <= ~v;
		req_length <= ~l;
	endtask
endmodule // dfusr_host_model
`default_nettype wire

// *** tb/dfu_status_responder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dfu_status_responder_tb import dfusr_pkg::*; ;
	localparam int unsigned CPM = 20; // Short millisecond for simulation.
	logic clock, rstn, psel, penable, pwrite, usb_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, e;
	logic tx_valid, tx_last, tx_ready, req_valid, req_ack, req_stall;
	logic [7:0] tx_data, req_type, req_code, code;
	logic [15:0] req_value, req_length;
	logic [3:0] dfu_state;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	dfusr_responder #(.CYC_PER_MS(CPM)) u_dfusr_responder (.clock(clock),
		.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_valid(req_valid), .req_type(req_type),
		.req_code(req_code), .req_value(req_value),
		.req_length(req_length), .usb_reset(usb_reset),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .req_ack(req_ack), .req_stall(req_stall),
		.dfu_state(dfu_state));
	dfusr_host_model u_dfusr_host_model (.clock(clock), .rstn(rstn),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .req_valid(req_valid), .req_type(req_type),
		.req_code(req_code), .req_value(req_value),
		.req_length(req_length));
	// The clock toggles every half period of 8 ns.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A hang is cut short well past the longest expected run.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		if (n == 50) begin
			err_total++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		apb(1'b0, a, 32'h0000_0000);
		chk("reg read", q, x);
		chk("reg error", e, xe);
	endtask
	task automatic state_is(input logic [3:0] x);
		@(posedge clock);
		#1;
		chk("state", dfu_state, x);
	endtask
	// Sends a data request and judges the first m of n returned bytes.
	task automatic xfer(input logic [7:0] t, input logic [7:0] c,
		input logic [15:0] v, input int n, input int m,
		input logic [55:0] x);
		int k;
		u_dfusr_host_model.rx_q.delete();
		u_dfusr_host_model.send(t, c, v, 16'(n));
		k = 0;
		while (u_dfusr_host_model.rx_q.size() < n && k < 300) begin
			@(posedge clock);
			k++;
		end
		chk("count", 32'(u_dfusr_host_model.rx_q.size()), n);
		for (int i = 0; i < m; i++) begin
			chk("byte", u_dfusr_host_model.rx_q[i][7:0], x[8*i+:8]);
		end
		chk("last", u_dfusr_host_model.rx_q[n-1][8], 1'b1);
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic wait_ack(input logic ack, input logic stall);
		int k;
		k = 0;
		// The answer rises on the edge that took the request; look after it.
		#1;
		while (req_ack !== 1'b1 && req_stall !== 1'b1 && k < 4) begin
			@(posedge clock);
			#1;
			k++;
		end
		chk("ack", req_ack, ack);
		chk("stall", req_stall, stall);
	endtask
	task automatic clear_err;
		u_dfusr_host_model.send(RT_CLASS_OUT, RQ_CLRSTATUS, 16'h0, 16'h0);
		wait_ack(1'b1, 1'b0);
		state_is(DS_DFU_IDLE);
	endtask
	task automatic t_reset;
		chk("reset state", dfu_state, 4'h2);
		rd_chk(REG_CTRL, 32'h0000_0003, 1'b0);
		rd_chk(REG_DETACH, 32'h0000_00FF, 1'b0);
		rd_chk(REG_XFER, 32'h0000_0040, 1'b0);
		rd_chk(REG_POLL, 32'h0000_0005, 1'b0);
		rd_chk(12'h018, 32'h0000_0000, 1'b1);
	endtask
	// descriptor layout, read by a stalling host.
	task automatic t_desc;
		u_dfusr_host_model.slow = 1'b1;
		apb(1'b1, REG_CTRL, 32'h0000_0007);
		apb(1'b1, REG_DETACH, 32'h0000_1234);
		apb(1'b1, REG_XFER, 32'h0000_0100);
		xfer(RT_STD_IN, RQ_GET_DESC, 16'h2100, 7, 7, 56'h01001234072107);
		apb(1'b1, REG_CTRL, 32'h0000_0002);
		xfer(RT_STD_IN, RQ_GET_DESC, 16'h2100, 7, 7, 56'h01001234022107);
		apb(1'b1, REG_CTRL, 32'h0000_0003);
		u_dfusr_host_model.slow = 1'b0;
	endtask
	task automatic t_codes;
		apb(1'b1, REG_POLL, 32'h0003_0201);
		for (int c = 1; c < 16; c++) begin
			code = 8'(c);
			apb(1'b1, REG_STATUS, {16'h0000, code ^ 8'h40, code});
			xfer(RT_CLASS_IN, RQ_GETSTATUS, 16'h0, 6, 6,
				{8'h00, code ^ 8'h40, 8'h0A, 24'h030201, code});
			chk("error state", dfu_state, DS_ERROR);
			clear_err();
			rd_chk(REG_STATUS, {16'h0002, code ^ 8'h40, 8'h00}, 1'b0);
		end
	endtask
	// early zero-length download and an unknown request.
	task automatic t_faults;
		u_dfusr_host_model.send(RT_CLASS_OUT, 8'h07, 16'h0, 16'h0);
		wait_ack(1'b0, 1'b1);
		xfer(RT_CLASS_IN, RQ_GETSTATUS, 16'h0, 6, 5, 56'h0A0302010F);
		clear_err();
		u_dfusr_host_model.send(RT_CLASS_OUT, RQ_DNLOAD, 16'h0, 16'h0);
		wait_ack(1'b1, 1'b0);
		xfer(RT_CLASS_IN, RQ_GETSTATUS, 16'h0, 6, 5, 56'h0A030201_09);
		clear_err();
		// The state query and an abort from upgrade idle.
		xfer(RT_CLASS_IN, RQ_GETSTATE, 16'h0, 1, 1, 56'h02);
		u_dfusr_host_model.send(RT_CLASS_OUT, RQ_ABORT, 16'h0, 16'h0);
		wait_ack(1'b1, 1'b0);
		state_is(DS_DFU_IDLE);
	endtask
	task automatic t_detach;
		apb(1'b1, REG_STATUS, 32'h0010_0000);
		state_is(DS_APP_IDLE);
		u_dfusr_host_model.send(RT_CLASS_OUT, RQ_DETACH, 16'h2, 16'h0);
		wait_ack(1'b1, 1'b0);
		state_is(DS_APP_DETACH);
		repeat (30) @(posedge clock);
		state_is(DS_APP_DETACH);
		repeat (30) @(posedge clock);
		state_is(DS_APP_IDLE);
		u_dfusr_host_model.send(RT_CLASS_OUT, RQ_DETACH, 16'h100, 16'h0);
		wait_ack(1'b1, 1'b0);
		@(posedge clock);
		usb_reset <= 1'b1;
		@(posedge clock);
		usb_reset <= 1'b0;
		state_is(DS_DFU_IDLE);
		apb(1'b1, REG_STATUS, 32'h0013_0000);
		@(posedge clock);
		usb_reset <= 1'b1;
		@(posedge clock);
		usb_reset <= 1'b0;
		state_is(DS_ERROR);
		rd_chk(REG_STATUS, 32'h000A_000C, 1'b0);
		// Last setup was the detach; its timer was stopped by the reset.
		rd_chk(REG_LASTREQ, 32'h0000_0021, 1'b0);
	endtask
	// Reset is held for eight cycles, then each scenario runs in turn.
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		usb_reset = 1'b0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
		t_reset();
		t_desc();
		t_codes();
		t_faults();
		t_detach();
		end_of_test();
	end
endmodule // dfu_status_responder_tb
`default_nettype wire
